// ### rtl/orc_pkg.sv
// constants for the output rounding control stage
// Operation
// - only the low eight bits of the round control word steer rounding.
// - bits three to zero set rounding of both summer path components.
// - bits seven to four set rounding of both product path components.
// - real and imaginary of one path always share one precision.
// - rounding adds a single one just below the lowest kept bit.
// - zero means no rounding; 1 to 12 keep 20 to 9 bits; above undefined.
// - the write strobe is taken asynchronously to the device clock; the code synchronises write_n_i to ref_clk_i and loads on its detected rise.
// - rounding applies only while round enable is low; else results pass unchanged.
package orc_pkg;
    localparam int         ORC_CTRL_W        = 16;
    localparam int         ORC_USED_W        = 8;
    localparam int         ORC_FIELD_W       = 4;
    localparam int         ORC_SUM_FIELD_LSB = 0;
    localparam int         ORC_PROD_FIELD_LSB = 4;
    localparam int         ORC_PROD_W        = 35;
    localparam int         ORC_SUM_W         = 20;
    localparam int         ORC_PROD_RND_BASE = 14;
    localparam int         ORC_SUM_RND_BASE  = -1;
    localparam int         ORC_BUF_DEPTH     = 2;
    localparam int         ORC_CLK_PERIOD_NS = 10;
    localparam logic [1:0] ORC_SEL_ROUND     = 2'h3;
    localparam logic [3:0] ORC_FIELD_MAX     = 4'hc;
    localparam logic [7:0] ORC_CTRL_RST      = 8'h00;
endpackage

// ### rtl/orc_round_lane.sv
// one rounding adder for a single result component
`timescale 1ns/100ps
module orc_round_lane #(
    parameter int W    = 20,
    parameter int BASE = -1
) (
    // setting
    input  wire logic [3:0]   field_i,
    input  wire logic         en_i,
    // data
    input  wire logic [W-1:0] value_i,
    output logic      [W-1:0] value_o
);
    import orc_pkg::*;

    if (W < 2) begin : g_chk
        $error("orc_round_lane: width too small");
    end

    int         pos;
    logic       do_rnd;
    logic [W-1:0] inc;

    assign pos    = BASE + int'(field_i) - 1;
    assign do_rnd = en_i && (field_i != 4'h0) && (field_i <= ORC_FIELD_MAX)
                    && (pos >= 0) && (pos < W);
    assign inc    = do_rnd ? (W'(1) << pos) : '0;
    assign value_o = value_i + inc;
endmodule

// ### rtl/orc_top.sv
// output rounding stage with round control register and two-entry output buffer
`timescale 1ns/100ps
module orc_top #(
    parameter int DEPTH = orc_pkg::ORC_BUF_DEPTH
) (
    // clock and reset
    input  wire logic                          ref_clk_i,
    input  wire logic                          rst_n_i,
    // control bus pins
    input  wire logic [orc_pkg::ORC_CTRL_W-1:0] control_bus_i,
    input  wire logic [1:0]                    register_select_i,
    input  wire logic                          chip_sel_n_i,
    input  wire logic                          write_n_i,
    input  wire logic                          round_enable_n_i,
    // unrounded results in
    input  wire logic                          in_valid_i,
    output logic                               in_ready_o,
    input  wire logic [orc_pkg::ORC_PROD_W-1:0] prod_real_i,
    input  wire logic [orc_pkg::ORC_PROD_W-1:0] prod_imag_i,
    input  wire logic [orc_pkg::ORC_SUM_W-1:0]  sum_real_i,
    input  wire logic [orc_pkg::ORC_SUM_W-1:0]  sum_imag_i,
    // rounded results out
    output logic                               out_valid_o,
    input  wire logic                          out_ready_i,
    output logic      [orc_pkg::ORC_PROD_W-1:0] prod_real_o,
    output logic      [orc_pkg::ORC_PROD_W-1:0] prod_imag_o,
    output logic      [orc_pkg::ORC_SUM_W-1:0]  sum_real_o,
    output logic      [orc_pkg::ORC_SUM_W-1:0]  sum_imag_o
);
    import orc_pkg::*;

    localparam int PW    = $clog2(DEPTH);
    localparam int ENT_W = 2 * ORC_PROD_W + 2 * ORC_SUM_W;

    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
        $error("orc_top: depth must be a power of two, at least 2");
    end

    // pin synchronisers
    logic [ORC_CTRL_W-1:0] bus_s1_q;
    logic [ORC_CTRL_W-1:0] bus_s2_q;
    logic [1:0]            sel_s1_q;
    logic [1:0]            sel_s2_q;
    logic                  cs_s1_q;
    logic                  cs_s2_q;
    logic                  wr_s1_q;
    logic                  wr_s2_q;
    logic                  wr_s3_q;
    logic                  rnd_s1_q;
    logic                  rnd_s2_q;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            bus_s1_q <= '0;
            bus_s2_q <= '0;
            sel_s1_q <= 2'h0;
            sel_s2_q <= 2'h0;
            cs_s1_q  <= 1'b1;
            cs_s2_q  <= 1'b1;
            wr_s1_q  <= 1'b1;
            wr_s2_q  <= 1'b1;
            wr_s3_q  <= 1'b1;
            rnd_s1_q <= 1'b1;
            rnd_s2_q <= 1'b1;
        end else begin
            bus_s1_q <= control_bus_i;
            bus_s2_q <= bus_s1_q;
            sel_s1_q <= register_select_i;
            sel_s2_q <= sel_s1_q;
            cs_s1_q  <= chip_sel_n_i;
            cs_s2_q  <= cs_s1_q;
            wr_s1_q  <= write_n_i;
            wr_s2_q  <= wr_s1_q;
            wr_s3_q  <= wr_s2_q;
            rnd_s1_q <= round_enable_n_i;
            rnd_s2_q <= rnd_s1_q;
        end
    end

    // round control register
    wire                  wr_rise   = wr_s2_q && !wr_s3_q;
    wire                  ctrl_load = wr_rise && !cs_s2_q && (sel_s2_q == ORC_SEL_ROUND);
    wire                  round_en  = !rnd_s2_q;
    logic [ORC_USED_W-1:0] ctrl_q;
    logic [ORC_USED_W-1:0] ctrl_d;

    assign ctrl_d = ctrl_load ? bus_s2_q[ORC_USED_W-1:0] : ctrl_q;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ctrl_q <= ORC_CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    wire [3:0] sum_field  = ctrl_q[ORC_SUM_FIELD_LSB +: ORC_FIELD_W];
    wire [3:0] prod_field = ctrl_q[ORC_PROD_FIELD_LSB +: ORC_FIELD_W];

    // rounding lanes, one setting per path
    logic [ORC_PROD_W-1:0] prod_real_rnd;
    logic [ORC_PROD_W-1:0] prod_imag_rnd;
    logic [ORC_SUM_W-1:0]  sum_real_rnd;
    logic [ORC_SUM_W-1:0]  sum_imag_rnd;

    orc_round_lane #(.W(ORC_PROD_W), .BASE(ORC_PROD_RND_BASE)) u_prod_real (
        .field_i (prod_field),
        .en_i    (round_en),
        .value_i (prod_real_i),
        .value_o (prod_real_rnd)
    );
    orc_round_lane #(.W(ORC_PROD_W), .BASE(ORC_PROD_RND_BASE)) u_prod_imag (
        .field_i (prod_field),
        .en_i    (round_en),
        .value_i (prod_imag_i),
        .value_o (prod_imag_rnd)
    );
    orc_round_lane #(.W(ORC_SUM_W), .BASE(ORC_SUM_RND_BASE)) u_sum_real (
        .field_i (sum_field),
        .en_i    (round_en),
        .value_i (sum_real_i),
        .value_o (sum_real_rnd)
    );
    orc_round_lane #(.W(ORC_SUM_W), .BASE(ORC_SUM_RND_BASE)) u_sum_imag (
        .field_i (sum_field),
        .en_i    (round_en),
        .value_i (sum_imag_i),
        .value_o (sum_imag_rnd)
    );

    // output buffer, rounded words are registered here
    logic [ENT_W-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [PW:0]      count_q;
    logic [PW:0]      count_d;

    wire              push    = in_valid_i && in_ready_o;
    wire              pop     = out_valid_o && out_ready_i;
    wire [ENT_W-1:0]  in_word = {prod_real_rnd, prod_imag_rnd, sum_real_rnd, sum_imag_rnd};
    wire [ENT_W-1:0]  head    = mem_q[rd_ptr_q];

    assign in_ready_o  = (count_q != (PW+1)'(DEPTH));
    assign out_valid_o = (count_q != '0);
    assign count_d     = count_q + (PW+1)'(push) - (PW+1)'(pop);
    assign prod_real_o = head[ENT_W-1 -: ORC_PROD_W];
    assign prod_imag_o = head[2*ORC_SUM_W +: ORC_PROD_W];
    assign sum_real_o  = head[ORC_SUM_W +: ORC_SUM_W];
    assign sum_imag_o  = head[0 +: ORC_SUM_W];

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                mem_q[wr_ptr_q] <= in_word;
                wr_ptr_q        <= wr_ptr_q + PW'(1);
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + PW'(1);
            end
            count_q <= count_d;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_ctrl_low_byte: assert property (
        ctrl_load |=> ctrl_q == $past(bus_s2_q[ORC_USED_W-1:0])
    ) else $error("round control did not take the low byte");

    a_write_pin_seq: assert property (
        $rose(write_n_i) && !chip_sel_n_i && register_select_i == ORC_SEL_ROUND
        && $stable(chip_sel_n_i) && $stable(register_select_i)
        && $stable(control_bus_i) && rst_n_i
        ##1 ($stable(chip_sel_n_i) && $stable(register_select_i)
        && $stable(control_bus_i) && write_n_i) [*3]
        |-> ctrl_q == control_bus_i[ORC_USED_W-1:0]
    ) else $error("strobe write not registered in time");

    a_ctrl_no_stray: assert property (
        !ctrl_load |=> $stable(ctrl_q)
    ) else $error("round control changed without a write");

    a_prod_step_one: assert property (
        round_en && prod_field == 4'h1
        |-> prod_real_rnd == prod_real_i + (ORC_PROD_W'(1) << 14)
    ) else $error("product rounding bit wrong for setting one");

    a_sum_step_three: assert property (
        round_en && sum_field == 4'h3
        |-> sum_imag_rnd == sum_imag_i + ORC_SUM_W'(2)
    ) else $error("summer rounding bit wrong for setting three");

    a_prod_step_max: assert property (
        round_en && prod_field == ORC_FIELD_MAX
        |-> prod_imag_rnd == prod_imag_i + (ORC_PROD_W'(1) << 25)
    ) else $error("product rounding bit wrong for nine bits kept");

    a_pair_same_prec: assert property (
        (prod_real_rnd - prod_real_i) == (prod_imag_rnd - prod_imag_i)
        && (sum_real_rnd - sum_real_i) == (sum_imag_rnd - sum_imag_i)
    ) else $error("real and imaginary rounded differently");

    a_zero_undef_pass: assert property (
        (prod_field == 4'h0 || prod_field > ORC_FIELD_MAX)
        |-> prod_real_rnd == prod_real_i
    ) else $error("product rounded with setting zero or undefined");

    a_disabled_pass: assert property (
        !round_en |-> in_word == {prod_real_i, prod_imag_i, sum_real_i, sum_imag_i}
    ) else $error("result rounded while round enable is high");

    a_reg_path: assert property (
        push && count_q == '0 && !pop
        |=> out_valid_o && head == $past(in_word)
    ) else $error("rounded word not registered to the output");

    a_stall_hold: assert property (
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(head)
    ) else $error("output word changed under stall");
endmodule

// ### bench/orc_host_model.sv
// host side model that loads the round control register over the control bus
`timescale 1ns/100ps
module orc_host_model (
    // clock
    input  wire logic                           ref_clk_i,
    // control bus pins
    output logic      [orc_pkg::ORC_CTRL_W-1:0] control_bus_o,
    output logic      [1:0]                     register_select_o,
    output logic                                chip_sel_n_o,
    output logic                                write_n_o
);
    import orc_pkg::*;
    initial begin
        control_bus_o     = 16'h5a5a;
        register_select_o = 2'h0;
        chip_sel_n_o      = 1'b1;
        write_n_o         = 1'b1;
    end
    // one write, called just after a clock edge; bus inverted once released
    task automatic write_word(input logic [15:0] word, input logic [1:0] sel);
        control_bus_o     = word;
        register_select_o = sel;
        chip_sel_n_o      = 1'b0;
        write_n_o         = 1'b0;
        repeat (3) @(posedge ref_clk_i);
        #1 write_n_o = 1'b1;
        repeat (5) @(posedge ref_clk_i);
        #1;
        chip_sel_n_o      = 1'b1;
        control_bus_o     = ~word;
        register_select_o = ~sel;
        repeat (3) @(posedge ref_clk_i);
        #1;
    endtask
endmodule

// ### bench/test_output_rounding_control.sv
// self-checking bench for the output rounding stage
`timescale 1ns/100ps
module test_output_rounding_control;
    import orc_pkg::*;
    logic                  ref_clk_i, rst_n_i, rnd_n, in_valid, in_ready, out_valid, out_ready;
    logic [ORC_CTRL_W-1:0] bus;
    logic [1:0]            sel;
    logic                  cs_n, wr_n;
    logic [ORC_PROD_W-1:0] pr_i, pi_i, pr_o, pi_o;
    logic [ORC_SUM_W-1:0]  sr_i, si_i, sr_o, si_o;
    int                    bad_count = 0;
    int                    comparisons = 0;
    orc_host_model orc_host_model_inst (.ref_clk_i(ref_clk_i), .control_bus_o(bus),
        .register_select_o(sel), .chip_sel_n_o(cs_n), .write_n_o(wr_n));
    orc_top orc_top_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .control_bus_i(bus),
        .register_select_i(sel), .chip_sel_n_i(cs_n), .write_n_i(wr_n),
        .round_enable_n_i(rnd_n), .in_valid_i(in_valid), .in_ready_o(in_ready),
        .prod_real_i(pr_i), .prod_imag_i(pi_i), .sum_real_i(sr_i), .sum_imag_i(si_i),
        .out_valid_o(out_valid), .out_ready_i(out_ready), .prod_real_o(pr_o),
        .prod_imag_o(pi_o), .sum_real_o(sr_o), .sum_imag_o(si_o));
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    task automatic close_out();
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [34:0] exp, input logic [34:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [34:0] rp(input logic [34:0] v, input logic [3:0] n);
        return (rnd_n || n == 4'h0 || n > ORC_FIELD_MAX) ? v : v + (35'h1 << (13 + n));
    endfunction
    function automatic logic [19:0] rs(input logic [19:0] v, input logic [3:0] n);
        return (rnd_n || n < 4'h2 || n > ORC_FIELD_MAX) ? v : v + (20'h1 << (n - 2));
    endfunction
    // offer one word and wait until it is taken
    task automatic push(input logic [34:0] p, input bit keep = 1'b0);
        int k;
        k = 0;
        in_valid = 1'b1;
        pr_i = p;
        pi_i = ~p;
        sr_i = p[19:0];
        si_i = p[34:15];
        while (in_ready !== 1'b1 && k < 50) begin
            @(posedge ref_clk_i);
            #1 k++;
        end
        cmp("in_ready", 35'h1, {34'h0, in_ready});
        @(posedge ref_clk_i);
        #1;
        if (!keep) begin
            in_valid = 1'b0;
        end
    endtask
    // wait for the head word, judge it, then pop it
    task automatic take(input logic [34:0] p, input logic [3:0] np, input logic [3:0] ns,
                        input bit keep = 1'b0);
        int k;
        k = 0;
        while (out_valid !== 1'b1 && k < 50) begin
            @(posedge ref_clk_i);
            #1 k++;
        end
        cmp("out_valid", 35'h1, {34'h0, out_valid});
        cmp("prod_real", rp(p, np), pr_o);
        cmp("prod_imag", rp(~p, np), pi_o);
        cmp("sum_real", {15'h0, rs(p[19:0], ns)}, {15'h0, sr_o});
        cmp("sum_imag", {15'h0, rs(p[34:15], ns)}, {15'h0, si_o});
        out_ready = 1'b1;
        @(posedge ref_clk_i);
        #1;
        if (!keep) begin
            out_ready = 1'b0;
        end
    endtask
    task automatic t_fields();
        for (int n = 0; n < 16; n++) begin
            orc_host_model_inst.write_word({8'hff, 4'(n), 4'(n + 5)}, 2'h3);
            push(35'h4_afff_ff00 + 35'(n));
            take(35'h4_afff_ff00 + 35'(n), 4'(n), 4'(n + 5));
        end
    endtask
    task automatic t_enable_and_refuse();
        orc_host_model_inst.write_word(16'h0033, 2'h3);
        rnd_n = 1'b1;
        repeat (4) @(posedge ref_clk_i);
        #1 push(35'h0_7fff_ffff);
        take(35'h0_7fff_ffff, 4'h3, 4'h3);
        rnd_n = 1'b0;
        orc_host_model_inst.write_word(16'h0077, 2'h2);
        push(35'h1_0000_0000);
        take(35'h1_0000_0000, 4'h3, 4'h3);
    endtask
    task automatic t_buffer();
        push(35'h2_1234_5678, 1'b1);
        push(35'h3_8765_4321);
        cmp("in_ready", 35'h0, {34'h0, in_ready});
        take(35'h2_1234_5678, 4'h3, 4'h3, 1'b1);
        take(35'h3_8765_4321, 4'h3, 4'h3);
        cmp("out_valid", 35'h0, {34'h0, out_valid});
    endtask
    initial begin
        #500000;
        bad_count++;
        close_out();
    end
    initial begin
        rst_n_i = 1'b0;
        rnd_n = 1'b0;
        in_valid = 1'b0;
        out_ready = 1'b0;
        {pr_i, pi_i, sr_i, si_i} = '0;
        repeat (16) @(posedge ref_clk_i);
        #1 rst_n_i = 1'b1;
        repeat (3) @(posedge ref_clk_i);
        #1 push(35'h7_ffff_f000);
        take(35'h7_ffff_f000, 4'h0, 4'h0);
        t_fields();
        t_enable_and_refuse();
        t_buffer();
        close_out();
    end
endmodule
